// *** hdl/drs_pkg.sv ***
// shared constants for the dram refresh sequencer
package drs_pkg;

  // dram geometry
  localparam int ROW_W       = 8;                    // refresh row address width
  localparam int ADDR_LO     = 2;                    // lowest cpu address bit used
  localparam int ADDR_HI     = 18;                   // highest cpu address bit used
  localparam int ROW_LSB     = 3;                    // row taken from address bits 10:3
  localparam int COL_LSB     = 11;                   // column from address bits 18:11
  localparam int BANK_BIT    = 2;                    // bank select address bit

  // timing: burst period in its own unit and as core cycles
  localparam int CLK_FREQ_MHZ    = 100;              // core_clk rate
  localparam int T_BURST_MS      = 4;                // one refresh period
  localparam int BURST_PERIOD_CYC = T_BURST_MS * 1000 * CLK_FREQ_MHZ;
  localparam int INTV_W          = 19;               // holds BURST_PERIOD_CYC - 1

  // reset values
  localparam logic [ROW_W-1:0]  ROW_RST  = 8'h00;    // row counter start
  localparam logic [ROW_W-1:0]  ROW_LAST = 8'hff;    // last row of a burst
  localparam logic [INTV_W-1:0] INTV_RST = 19'h00000; // interval counter start

  // pin synchroniser lanes
  localparam int SY_TIMER = 0;                       // timer refresh, active low
  localparam int SY_GRANT = 1;                       // bus grant acknowledge
  localparam int SY_WARM  = 2;                       // external warm-up request
  localparam int SY_DMA   = 3;                       // dma refresh mode strap
  localparam int SY_W     = 4;                       // number of synced pins

  // controller sequencer states
  typedef enum logic [2:0] {
    DRS_IDLE,
    DRS_ACC_ROW,
    DRS_ACC_COL,
    DRS_ACC_END,
    DRS_REF_RAS,
    DRS_REF_HOLD,
    DRS_REF_END
  } drs_state_t;

endpackage

// *** hdl/drs_refresh_seq.sv ***
// Contract
// - burst mode refreshes all 256 rows consecutively
// - no refresh for next period after burst
// - interval counter spans full 4 ms period
// - request held active through 256 refresh cycles
// - row counter cleared first, burst ends on wrap
// - row strobe advances row counter once per refresh
// - dma request is timer AND grant, both banks
// - chip selects ignored in dma refresh mode
// - ready returned at end of dma refresh
// - dma mode keeps mux driven, row A10:3
// - any bad state returns to idle quickly
// - counters work from any starting value
// - refresh continues through processor halt or reset
// - refresh first, but running access completes
// - refresh is ras-only, cas idle, data undriven
// - row counter increments after each refresh
`timescale 1ns/1ns
module drs_refresh_seq #(
  parameter int BURST_PERIOD = drs_pkg::BURST_PERIOD_CYC     // cycles per burst period
) (
  input  wire logic                                     core_clk,   // system clock
  input  wire logic                                     resetn,     // sync reset, low
  input  wire logic                                     clk_en,     // freezes all state
  input  wire logic                                     dma_mode_pin, // dma refresh strap
  input  wire logic                                     timer_refresh_output_n, // timer req
  input  wire logic                                     bus_grant_ack, // cpu hold ack
  input  wire logic                                     warmup_req, // external refresh hold
  input  wire logic                                     chip_sel,   // access request
  input  wire logic [drs_pkg::ADDR_HI:drs_pkg::ADDR_LO] cpu_addr,   // access address
  output logic                                          refresh_request, // pending refresh
  output logic [1:0]                                    ras_n,      // bank row strobes
  output logic [1:0]                                    cas_n,      // bank column strobes
  output logic [drs_pkg::ROW_W-1:0]                     dram_addr,  // multiplexed address
  output logic                                          mux_oe,     // address mux drives
  output logic                                          rfaddr_oe,  // row counter drives
  output logic                                          data_oe,    // data buffers enable
  output logic                                          row_select_strobe, // mux to column
  output logic                                          ready       // bus ready pulse
);
  import drs_pkg::*;

  localparam logic [INTV_W-1:0] INTV_LAST = INTV_W'(BURST_PERIOD - 1); // terminal count

  // active low strobe pair for one bank; shared by row and column phases
  function automatic logic [1:0] bank_strobe(input logic bank);
    return bank ? 2'b01 : 2'b10;
  endfunction

  // state
  drs_state_t              state_reg, state_next;     // dram_timing_logic sequencer
  logic [SY_W-1:0]         sync1_reg;                 // first synchroniser stage
  logic [SY_W-1:0]         sync2_reg;                 // second synchroniser stage
  logic                    dma_req_d_reg;             // delayed dma request for edge
  logic                    dma_pend_reg;              // held dma refresh request
  logic                    burst_active_reg;          // burst in progress
  logic [INTV_W-1:0]       intv_reg;                  // refresh interval counter
  logic [ROW_W-1:0]        row_reg;                   // row refresh address counter
  logic                    bank_reg;                  // bank of current access
  logic [1:0]              ras_n_reg, ras_n_next;     // registered row strobes
  logic [1:0]              cas_n_reg, cas_n_next;     // registered column strobes
  logic [ROW_W-1:0]        addr_reg, addr_next;       // registered dram address
  logic                    mux_oe_reg, mux_oe_next;   // registered mux enable
  logic                    data_oe_reg, data_oe_next; // registered data enable
  logic                    row_select_strobe_reg, row_select_strobe_next;   // registered row select strobe
  logic                    ready_reg, ready_next;     // registered ready pulse

  // decoded conditions
  wire dma_mode    = sync2_reg[SY_DMA];                                    // mode strap
  wire dma_req     = ~sync2_reg[SY_TIMER] & sync2_reg[SY_GRANT];
  wire dma_rise    = dma_req & ~dma_req_d_reg;                             // new dma request
  wire warm        = sync2_reg[SY_WARM];
  wire ref_req     = (dma_mode ? dma_pend_reg : burst_active_reg) | warm;
  wire acc_req     = chip_sel & ~dma_mode;
  wire ref_accept  = (state_reg == DRS_IDLE) & ref_req;
  wire ref_done    = (state_reg == DRS_REF_END);                           // refresh finishing
  wire row_step    = ref_done & row_select_strobe_reg;
  wire intv_tc     = (intv_reg == INTV_LAST);
  wire burst_start = ~dma_mode & ~burst_active_reg & intv_tc;
  wire burst_end   = burst_active_reg & row_step & (row_reg == ROW_LAST);
  wire [ROW_W-1:0] row_of_cpu = cpu_addr[ROW_LSB +: ROW_W];
  wire [ROW_W-1:0] col_of_cpu = cpu_addr[COL_LSB +: ROW_W];                // column half

  // pin synchronisers; no process reads the first stage but the second
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      sync1_reg <= {dma_mode_pin, warmup_req, bus_grant_ack, timer_refresh_output_n};
      sync2_reg <= sync1_reg;
    end
  end

  // held dma request; a new request in the accept cycle wins
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dma_req_d_reg <= 1'b0;
      dma_pend_reg  <= 1'b0;
    end else if (clk_en) begin
      dma_req_d_reg <= dma_req;
      if (dma_rise) begin
        dma_pend_reg <= 1'b1;
      end else if (ref_accept && dma_mode) begin
        dma_pend_reg <= 1'b0;
      end
    end
  end

  // burst control: interval count, burst flag
  // reset only gives simulation a clean start; no decision relies on it
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      burst_active_reg <= 1'b0;
      intv_reg         <= INTV_RST;
    end else if (clk_en) begin
      if (burst_start) begin
        burst_active_reg <= 1'b1;
        intv_reg         <= INTV_RST;
      end else if (burst_end) begin
        burst_active_reg <= 1'b0;
        intv_reg         <= INTV_RST;
      end else if (dma_mode || burst_active_reg) begin
        intv_reg         <= INTV_RST;                        // idle while bursting
      end else if (intv_tc || intv_reg > INTV_LAST) begin
        intv_reg         <= INTV_RST;                        // out of range wraps
      end else begin
        intv_reg         <= intv_reg + 1'b1;
      end
    end
  end

  // row refresh address counter; clear on burst start beats a step
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      row_reg <= ROW_RST;
    end else if (clk_en) begin
      if (burst_start) begin
        row_reg <= ROW_RST;
      end else if (row_step) begin
        row_reg <= row_reg + 1'b1;
      end
    end
  end

  // sequencer next state and output values
  always_comb begin
    state_next   = state_reg;
    ras_n_next   = 2'b11;
    cas_n_next   = 2'b11;
    addr_next    = addr_reg;
    mux_oe_next  = 1'b1;
    data_oe_next = 1'b0;
    row_select_strobe_next  = 1'b0;
    ready_next   = 1'b0;
    case (state_reg)
      DRS_IDLE: begin
        if (ref_req) begin                                   // refresh first
          state_next  = DRS_REF_RAS;
          ras_n_next  = 2'b00;                               // both banks
          addr_next   = dma_mode ? row_of_cpu : row_reg;
          mux_oe_next = dma_mode;
        end else if (acc_req) begin
          state_next  = DRS_ACC_ROW;
          ras_n_next  = bank_strobe(cpu_addr[BANK_BIT]);
          addr_next   = row_of_cpu;
        end
      end
      DRS_ACC_ROW: begin                                     // switch mux to column
        state_next   = DRS_ACC_COL;
        ras_n_next   = bank_strobe(bank_reg);
        addr_next    = col_of_cpu;
        row_select_strobe_next  = 1'b1;
        data_oe_next = 1'b1;
      end
      DRS_ACC_COL: begin
        state_next   = DRS_ACC_END;
        ras_n_next   = bank_strobe(bank_reg);
        cas_n_next   = bank_strobe(bank_reg);
        data_oe_next = 1'b1;
        ready_next   = 1'b1;                                 // access done
      end
      DRS_ACC_END: begin                                     // precharge, then refresh may go
        state_next = DRS_IDLE;
      end
      DRS_REF_RAS: begin                                     // ras only
        state_next  = DRS_REF_HOLD;
        ras_n_next  = 2'b00;
        mux_oe_next = dma_mode;
      end
      DRS_REF_HOLD: begin
        state_next  = DRS_REF_END;
        ras_n_next  = 2'b00;
        mux_oe_next = dma_mode;
        row_select_strobe_next = 1'b1;                                  // one strobe per refresh
        ready_next  = dma_mode;
      end
      DRS_REF_END: begin                                     // ras precharge
        state_next  = DRS_IDLE;
        mux_oe_next = dma_mode;
      end
      default: begin                                         // bad code to idle
        state_next = DRS_IDLE;
      end
    endcase
  end

  // sequencer registers; the processor's own reset does not reach here
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg   <= DRS_IDLE;
      bank_reg    <= 1'b0;
      ras_n_reg   <= 2'b11;
      cas_n_reg   <= 2'b11;
      addr_reg    <= ROW_RST;
      mux_oe_reg  <= 1'b1;
      data_oe_reg <= 1'b0;
      row_select_strobe_reg  <= 1'b0;
      ready_reg   <= 1'b0;
    end else if (clk_en) begin
      state_reg   <= state_next;
      if (state_reg == DRS_IDLE) begin
        bank_reg  <= cpu_addr[BANK_BIT];                     // latch bank of access
      end
      ras_n_reg   <= ras_n_next;
      cas_n_reg   <= cas_n_next;                             // no cas in refresh
      addr_reg    <= addr_next;
      mux_oe_reg  <= mux_oe_next;
      data_oe_reg <= data_oe_next;                           // data undriven
      row_select_strobe_reg  <= row_select_strobe_next;
      ready_reg   <= ready_next;
    end
  end

  // outputs
  assign refresh_request   = ref_req;
  assign ras_n             = ras_n_reg;
  assign cas_n             = cas_n_reg;
  assign dram_addr         = addr_reg;
  assign mux_oe            = mux_oe_reg;
  assign rfaddr_oe         = ~mux_oe_reg;                    // row counter drives instead
  assign data_oe           = data_oe_reg;
  assign row_select_strobe = row_select_strobe_reg;
  assign ready             = ready_reg;

endmodule // drs_refresh_seq

// *** dv/drs_refresh_seq_properties.sv ***
`timescale 1ns/1ns
// port-level timing checks of refresh and access strobes
module drs_refresh_seq_chk #(
  parameter int BURST_PERIOD = drs_pkg::BURST_PERIOD_CYC // same count as the block
) (
  input wire logic                        core_clk,          // clock
  input wire logic                        resetn,            // sync reset, low
  input wire logic                        refresh_request,   // refresh wanted
  input wire logic [1:0]                  ras_n,             // row strobes
  input wire logic [1:0]                  cas_n,             // column strobes
  input wire logic [drs_pkg::ROW_W-1:0]   dram_addr,         // mux address
  input wire logic                        mux_oe,            // cpu mux drives
  input wire logic                        rfaddr_oe,         // row counter drives
  input wire logic                        data_oe,           // data enable
  input wire logic                        row_select_strobe, // mux switch
  input wire logic                        ready              // bus ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] prev_row_reg; // row the last strobe stepped from
  logic       prev_vld_reg; // cleared between bursts, a new burst restarts at zero
  // remember the row of each counter-driven refresh
  always_ff @(posedge core_clk) begin
    if (!resetn || !refresh_request) begin
      prev_vld_reg <= 1'b0;
    end else if (rfaddr_oe && row_select_strobe) begin
      prev_row_reg <= dram_addr;
      prev_vld_reg <= 1'b1;
    end
  end
  property p_ref_quiet;
    ras_n == 2'b00 |-> cas_n == 2'b11 && !data_oe;
  endproperty
  a_ref_quiet: assert property (p_ref_quiet) else $error("refresh drove cas or data");
  property p_ref_len;
    ras_n == 2'b00 && $past(ras_n) != 2'b00 |-> (ras_n == 2'b00)[*3] ##1 ras_n == 2'b11;
  endproperty
  a_ref_len: assert property (p_ref_len) else $error("refresh strobe length wrong");
  property p_row_step;
    rfaddr_oe && ras_n == 2'b00 && $past(ras_n) != 2'b00 && prev_vld_reg
      |-> dram_addr == prev_row_reg + 8'h01;
  endproperty
  a_row_step: assert property (p_row_step) else $error("row did not step");
  // the row counter may only drive the address while a refresh strobe runs or precharges
  property p_oe_pair;
    rfaddr_oe != mux_oe && (!rfaddr_oe || ras_n == 2'b00 || $past(ras_n) == 2'b00);
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("address drivers clash");
  property p_burst_no_rdy;
    rfaddr_oe && ras_n == 2'b00 |-> !ready;
  endproperty
  a_burst_no_rdy: assert property (p_burst_no_rdy) else $error("ready in burst");
  property p_req_taken;
    $rose(refresh_request) |-> ##[1:6] ras_n == 2'b00;
  endproperty
  a_req_taken: assert property (p_req_taken) else $error("request not taken");
  property p_cas_ready;
    cas_n != 2'b11 |-> ready && data_oe && $past(row_select_strobe);
  endproperty
  a_cas_ready: assert property (p_cas_ready) else $error("cas without ready");
  property p_acc_seq;
    ras_n != 2'b11 && ras_n != 2'b00 && $past(ras_n) == 2'b11
      |=> row_select_strobe && data_oe ##1 cas_n == ras_n && ready ##1 ras_n == 2'b11;
  endproperty
  a_acc_seq: assert property (p_acc_seq) else $error("access sequence wrong");
endmodule // drs_refresh_seq_chk
bind drs_refresh_seq drs_refresh_seq_chk #(.BURST_PERIOD(BURST_PERIOD)) drs_refresh_seq_chk_inst (
  .core_clk(core_clk), .resetn(resetn), .refresh_request(refresh_request), .ras_n(ras_n),
  .cas_n(cas_n), .dram_addr(dram_addr), .mux_oe(mux_oe), .rfaddr_oe(rfaddr_oe),
  .data_oe(data_oe), .row_select_strobe(row_select_strobe), .ready(ready));

// *** dv/drs_dma_host.sv ***
`timescale 1ns/1ns
// stand-in for the dma refresh controller and the processor hold logic
module drs_dma_host (
  input  wire logic                                     core_clk,               // clock
  input  wire logic                                     go,                     // one request
  input  wire logic                                     no_grant,               // cpu keeps bus
  output logic                                          timer_refresh_output_n, // timer, low
  output logic                                          bus_grant_ack,          // hold ack
  output logic                                          drive,                  // owns bus
  output logic [drs_pkg::ADDR_HI:drs_pkg::ADDR_LO]      addr                    // refresh addr
);
  logic [23:0] ref_cnt_reg = 24'h000000; // refresh address, one row per step
  logic [3:0]  hold_reg = 4'h0;          // request cycles left
  // held long enough to cross the block's synchroniser and be taken
  always @(posedge core_clk) begin
    if (go) begin
      hold_reg <= 4'hc;
    end else if (hold_reg != 4'h0) begin
      hold_reg <= hold_reg - 4'h1;
      if (hold_reg == 4'h1) ref_cnt_reg <= ref_cnt_reg + 24'h000008;
    end
  end
  assign drive = hold_reg != 4'h0;
  assign timer_refresh_output_n = !drive;
  assign bus_grant_ack = drive && !no_grant; // refresh wins arbitration at once unless no_grant keeps the bus with the cpu
  // a released bus shows junk, never the last value
  assign addr = drive ? ref_cnt_reg[18:2] : ~ref_cnt_reg[18:2];
endmodule // drs_dma_host

// *** dv/tb_drs_refresh_seq.sv ***
`timescale 1ns/1ns
// bench: cpu access, burst refresh, dma refresh and warm-up runs
module tb_drs_refresh_seq;
  localparam int BP = 64; // shortened burst period
  logic        core_clk = 1'b0, resetn = 1'b0, dma_mode = 1'b0, warmup = 1'b0;
  logic        chip_sel = 1'b0, go = 1'b0, no_grant = 1'b0; // bench-driven controls
  logic        drv, tmr_n, grant, refresh_request, row_select_strobe, ready;
  logic        mux_oe, rfaddr_oe, data_oe;
  logic [1:0]  ras_n, cas_n, prev;  // strobes and last seen row strobes
  logic [7:0]  dram_addr;           // multiplexed address
  logic [18:2] baddr = 17'h00000, maddr, cpu_addr; // bench, host and bus address
  int          num_errors = 0, n_checks = 0, n; // tallies
  assign cpu_addr = drv ? maddr : baddr; // host owns the bus while it refreshes
  drs_refresh_seq #(.BURST_PERIOD(BP)) drs_refresh_seq_inst (.core_clk(core_clk),
    .resetn(resetn), .clk_en(1'b1), .dma_mode_pin(dma_mode), .timer_refresh_output_n(tmr_n),
    .bus_grant_ack(grant), .warmup_req(warmup), .chip_sel(chip_sel), .cpu_addr(cpu_addr),
    .refresh_request(refresh_request), .ras_n(ras_n), .cas_n(cas_n), .dram_addr(dram_addr),
    .mux_oe(mux_oe), .rfaddr_oe(rfaddr_oe), .data_oe(data_oe),
    .row_select_strobe(row_select_strobe), .ready(ready));
  drs_dma_host drs_dma_host_inst (.core_clk(core_clk), .go(go), .no_grant(no_grant),
    .timer_refresh_output_n(tmr_n), .bus_grant_ack(grant), .drive(drv), .addr(maddr));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d of %0d compares", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // count refresh starts over a span of cycles
  task automatic count_ref(int cyc, output int cnt);
    cnt = 0;
    repeat (cyc) begin
      prev = ras_n;
      @(posedge core_clk) #1;
      if (ras_n == 2'b00 && prev != 2'b00) cnt++;
    end
  endtask
  // bank 1 access; takes five edges
  task automatic t_access;
    @(posedge core_clk) chip_sel <= 1'b1;
    baddr <= {8'h5a, 8'hc3, 1'b1};
    @(posedge core_clk) #1;
    chk("acc row", {2'b01, 8'hc3}, {ras_n, dram_addr});
    @(posedge core_clk) #1;
    chk("acc col", {1'b1, 8'h5a}, {row_select_strobe, dram_addr});
    @(posedge core_clk) #1;
    chk("acc end", 3'b011, {cas_n, ready});
    @(posedge core_clk) chip_sel <= 1'b0;
    $display("access test done");
  endtask
  // full burst of rows 0..255, then a quiet period with an access in it
  task automatic t_burst;
    int t;
    n = 0;
    t = 0;
    while (!refresh_request && t < 4 * BP) begin
      @(posedge core_clk) #1;
      t++;
    end
    t = 0;
    while (t < 1300 && !(t > 1040 && refresh_request)) begin
      prev = ras_n;
      @(posedge core_clk) #1;
      t++;
      if (ras_n == 2'b00 && prev != 2'b00) begin
        chk("burst row", n[7:0], dram_addr);
        n++;
      end
      if (t == 1040) begin
        t_access();
        t = t + 5;
      end
    end
    chk("burst count", 256, n);
    chk("quiet span", 1, t >= 1022 + BP && t <= 1027 + BP);
    $display("burst test done");
  endtask
  // dma refresh needs timer and grant; row from A10:3; chip select ignored
  task automatic t_dma;
    int c;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk) go <= 1'b1;
      no_grant <= (i == 1);
      chip_sel <= 1'b1;
      @(posedge core_clk) go <= 1'b0;
      c = 0;
      repeat (30) begin
        prev = ras_n;
        @(posedge core_clk) #1;
        if (ras_n == 2'b00 && prev != 2'b00) begin
          chk("dma row", {1'b1, i[7:0]}, {mux_oe, dram_addr});
          c++;
        end
        if (ras_n == 2'b00 && row_select_strobe) chk("dma ready", 1, ready);
        chk("cs ignored", 2'b11, cas_n);
      end
      chk("dma count", i != 1, c);
    end
    @(posedge core_clk) chip_sel <= 1'b0;
    $display("dma test done");
  endtask
  // warm-up level runs refreshes back to back, none after it drops
  task automatic t_warm;
    @(posedge core_clk) warmup <= 1'b1;
    count_ref(40, n);
    chk("warm runs", 1, n >= 8);
    @(posedge core_clk) warmup <= 1'b0;
    count_ref(8, n);
    count_ref(30, n);
    chk("warm stop", 0, n);
    $display("warm-up test done");
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    chk("reset outs", 7'h7c, {ras_n, cas_n, mux_oe, rfaddr_oe, ready});
    t_access();
    t_burst();
    while (refresh_request) @(posedge core_clk) #1;
    @(posedge core_clk) dma_mode <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_dma();
    t_warm();
    close_out();
  end
  // hang guard, well beyond the expected run
  initial begin
    #(20000 * 10);
    num_errors++;
    close_out();
  end
endmodule // tb_drs_refresh_seq
